/* File: hw/bcse_exec.sv */
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bcse_params.svh"

// Operation
// - ED B8 copies byte at source to target, then decrements source, target, counter.
// - Copy ends when counter hits zero; otherwise PC moves back two and repeats.
// - Between repeats interrupts are accepted; two refresh cycles precede each byte.
// - Copy starting with counter zero wraps and moves 64 Kbytes.
// - Copy keeps sign and equal flags; clears nibble borrow, parity, subtract.
// - ED A1 compares accumulator with source byte, source up, counter down.
// - Compare sets sign, equal, bit 4 borrow, counter-nonzero, subtract; carry kept.
// - Compare changes only flags, source pointer and counter.
// - ED B1 repeats upward compare until counter zero or a match.
// - Search starting with counter zero wraps over 64 Kbytes unless matched.
// - ED A9 compares, then decrements source pointer and counter.
// - ED B9 repeats downward compare until counter zero or a match.
module bcse_exec (
    input wire logic sys_clk, // 50 MHz system clock
    input wire logic rst, // Synchronous reset, high
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Bus write
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [3:0] wb_sel_i, // Byte enables
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Bus acknowledge
    output bcse_pkg::bcse_word_t memAddr, // Memory address
    output bcse_pkg::bcse_byte_t memWrData, // Memory write byte
    input wire bcse_pkg::bcse_byte_t memRdData, // Memory read byte
    output logic memRd, // Memory read request
    output logic memWr, // Memory write request
    output logic memRfsh, // Refresh state
    input wire logic memWait, // Memory wait state
    input wire logic intReq, // Interrupt pending pin
    output logic execBusy // Instruction running
);
    import bcse_pkg::*;

    bcse_state_t q;
    bcse_state_t n;
    logic isCopy;
    logic rdStall;
    logic wrStall;
    logic stall;
    logic fifoPush;
    logic fifoPop;
    logic fifoInReady;
    logic fifoOutValid;
    bcse_byte_t fifoData;
    logic [2:0] tLast;
    logic [8:0] diff;
    bcse_word_t cntDec;
    logic match;
    logic halfBorrow;
    logic again;
    logic endExec;
    logic endRep;

    // Last clock state index of each machine cycle
    function automatic logic [2:0] lastOf(bcse_phase_t p);
        case (p)
            PH_FETCH1, PH_FETCH2: lastOf = 3'(`BCSE_T_FETCH - 1);
            PH_READ: lastOf = 3'(`BCSE_T_READ - 1);
            PH_EXEC: lastOf = 3'(`BCSE_T_EXEC - 1);
            default: lastOf = 3'(`BCSE_T_REPEAT - 1);
        endcase
    endfunction : lastOf

    // Merge the two low byte lanes of a write into a 16-bit register
    function automatic bcse_word_t merge16(bcse_word_t old, logic [31:0] d, logic [3:0] s);
        merge16 = old;
        if (s[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (s[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction : merge16

    // Stalls: memory wait, full buffer on read, empty buffer before write
    assign isCopy = q.op == OPK_COPY_DN;
    assign rdStall = q.memRd && (q.tCnt == 3'd1)
        && (memWait || (q.phase == PH_READ && isCopy && !fifoInReady));
    assign wrStall = (q.phase == PH_EXEC) && isCopy
        && ((q.tCnt == 3'd0 && !fifoOutValid) || (q.tCnt == 3'd2 && memWait));
    assign stall = rdStall || wrStall;
    assign fifoPush = (q.phase == PH_READ) && isCopy && (q.tCnt == 3'd1) && q.memRd && !memWait;
    assign fifoPop = (q.phase == PH_EXEC) && isCopy && (q.tCnt == 3'd0);
    assign tLast = lastOf(q.phase);

    // Compare arithmetic, never written back to the accumulator
    assign diff = {1'b0, q.acc} - {1'b0, q.data};
    assign match = q.acc == q.data;
    assign halfBorrow = q.acc[3:0] < q.data[3:0];
    assign cntDec = q.cnt - 16'h0001;
    // Zero start count wraps to ffff here, so the loop runs the full range
    assign again = q.rep && (cntDec != 16'h0000) && (isCopy || !match);
    assign endExec = q.busy && q.phase == PH_EXEC && q.tCnt == tLast && !stall;
    assign endRep = q.busy && q.phase == PH_REPEAT && q.tCnt == tLast && !stall;

    // Copied byte passes a buffer between the read and the write cycle
    bcse_fifo #(
        .W(`BCSE_DATA_W),
        .D(`BCSE_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .inData(memRdData),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    // Next-state logic: bus slave, sequencer, then registered outputs
    always_comb begin
        n = q;
        n.irqS1 = intReq;
        n.irqS2 = q.irqS1;
        n.wbAck = wb_cyc_i && wb_stb_i && !q.wbAck;
        case (wb_adr_i)
            `BCSE_OFS_PC: n.wbDat = {16'h0000, q.pc};
            `BCSE_OFS_SRC: n.wbDat = {16'h0000, q.src};
            `BCSE_OFS_TGT: n.wbDat = {16'h0000, q.tgt};
            `BCSE_OFS_CNT: n.wbDat = {16'h0000, q.cnt};
            `BCSE_OFS_ACCFLG: n.wbDat = {16'h0000, q.flags, q.acc};
            `BCSE_OFS_STATUS: n.wbDat = {19'h00000, q.iterT, 4'h0,
                q.intTaken, q.badOp, q.done, q.busy};
            default: n.wbDat = 32'h00000000;
        endcase
        // Writes land on the edge that ends the ack cycle; operands locked while busy
        if (q.wbAck && wb_we_i) begin
            case (wb_adr_i)
                `BCSE_OFS_CTRL: begin
                    if (wb_sel_i[0] && wb_dat_i[`BCSE_CTRL_START] && !q.busy) begin
                        n.busy = 1'b1;
                        n.phase = PH_FETCH1;
                        n.tCnt = 3'd0;
                        n.iterT = 5'd0;
                    end
                end
                `BCSE_OFS_PC: n.pc = q.busy ? q.pc : merge16(q.pc, wb_dat_i, wb_sel_i);
                `BCSE_OFS_SRC: n.src = q.busy ? q.src : merge16(q.src, wb_dat_i, wb_sel_i);
                `BCSE_OFS_TGT: n.tgt = q.busy ? q.tgt : merge16(q.tgt, wb_dat_i, wb_sel_i);
                `BCSE_OFS_CNT: n.cnt = q.busy ? q.cnt : merge16(q.cnt, wb_dat_i, wb_sel_i);
                `BCSE_OFS_ACCFLG: begin
                    if (!q.busy) begin
                        {n.flags, n.acc} = merge16({q.flags, q.acc}, wb_dat_i, wb_sel_i);
                    end
                end
                `BCSE_OFS_STATUS: begin
                    if (wb_sel_i[0]) begin
                        n.done = q.done && !wb_dat_i[`BCSE_ST_DONE];
                        n.badOp = q.badOp && !wb_dat_i[`BCSE_ST_BADOP];
                        n.intTaken = q.intTaken && !wb_dat_i[`BCSE_ST_INT];
                    end
                end
                default: begin
                end
            endcase
        end
        // Sequencer; sets below come after the clears, so a set wins
        if (q.busy && !stall) begin
            n.iterT = q.iterT + 5'd1;
            if (q.memRd && q.tCnt == 3'd1) begin
                n.data = memRdData;
            end
            if (fifoPop) begin
                n.memWrData = fifoData;
            end
            if (q.tCnt != tLast) begin
                n.tCnt = q.tCnt + 3'd1;
            end else begin
                n.tCnt = 3'd0;
                case (q.phase)
                    PH_FETCH1: begin
                        n.pc = q.pc + 16'h0001;
                        if (q.data == `BCSE_OP_PREFIX) begin
                            n.phase = PH_FETCH2;
                        end else begin
                            n.phase = PH_IDLE;
                            n.busy = 1'b0;
                            n.badOp = 1'b1;
                        end
                    end
                    PH_FETCH2: begin
                        n.pc = q.pc + 16'h0001;
                        n.phase = PH_READ;
                        case (q.data)
                            `BCSE_OP_COPY_DN_R: begin
                                n.op = OPK_COPY_DN;
                                n.rep = 1'b1;
                            end
                            `BCSE_OP_CMP_UP: begin
                                n.op = OPK_CMP_UP;
                                n.rep = 1'b0;
                            end
                            `BCSE_OP_CMP_UP_R: begin
                                n.op = OPK_CMP_UP;
                                n.rep = 1'b1;
                            end
                            `BCSE_OP_CMP_DN: begin
                                n.op = OPK_CMP_DN;
                                n.rep = 1'b0;
                            end
                            `BCSE_OP_CMP_DN_R: begin
                                n.op = OPK_CMP_DN;
                                n.rep = 1'b1;
                            end
                            default: begin
                                n.phase = PH_IDLE;
                                n.busy = 1'b0;
                                n.badOp = 1'b1;
                            end
                        endcase
                    end
                    PH_READ: n.phase = PH_EXEC;
                    PH_EXEC: begin
                        n.cnt = cntDec;
                        if (isCopy) begin
                            n.src = q.src - 16'h0001;
                            n.tgt = q.tgt - 16'h0001;
                            n.flags[`BCSE_FLG_H] = 1'b0;
                            n.flags[`BCSE_FLG_PV] = 1'b0;
                            n.flags[`BCSE_FLG_N] = 1'b0;
                        end else begin
                            if (q.op == OPK_CMP_UP) begin
                                n.src = q.src + 16'h0001;
                            end else begin
                                n.src = q.src - 16'h0001;
                            end
                            n.flags[`BCSE_FLG_S] = diff[7];
                            n.flags[`BCSE_FLG_Z] = match;
                            n.flags[`BCSE_FLG_H] = halfBorrow;
                            n.flags[`BCSE_FLG_PV] = cntDec != 16'h0000;
                            n.flags[`BCSE_FLG_N] = 1'b1;
                        end
                        // Counter zero, a compare match or a non-repeating op ends; otherwise one more cycle
                        if (again) begin
                            n.phase = PH_REPEAT;
                        end else begin
                            n.phase = PH_IDLE;
                            n.busy = 1'b0;
                            n.done = 1'b1;
                        end
                    end
                    PH_REPEAT: begin
                        n.pc = q.pc - `BCSE_PC_REWIND;
                        n.iterT = 5'd0;
                        // PC left on the prefix, so a restart resumes the loop
                        if (q.irqS2) begin
                            n.phase = PH_IDLE;
                            n.busy = 1'b0;
                            n.intTaken = 1'b1;
                        end else begin
                            n.phase = PH_FETCH1;
                        end
                    end
                    default: begin
                        n.phase = PH_IDLE;
                        n.busy = 1'b0;
                    end
                endcase
            end
        end
        // Bus pins follow the next state so they leave flip-flops
        n.memRd = n.busy && (n.phase == PH_FETCH1 || n.phase == PH_FETCH2
            || n.phase == PH_READ) && (n.tCnt < 3'd2);
        n.memWr = n.busy && n.phase == PH_EXEC && n.op == OPK_COPY_DN
            && (n.tCnt == 3'd1 || n.tCnt == 3'd2);
        // Refresh closes each opcode fetch: two per iteration
        n.memRfsh = n.busy && (n.phase == PH_FETCH1 || n.phase == PH_FETCH2)
            && (n.tCnt >= 3'd2);
        case (n.phase)
            PH_FETCH1, PH_FETCH2: n.memAddr = n.pc;
            PH_READ: n.memAddr = n.src;
            PH_EXEC: n.memAddr = isCopy || n.op == OPK_COPY_DN ? n.tgt : q.memAddr;
            default: n.memAddr = q.memAddr;
        endcase
    end

    // Single state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign wb_dat_o = q.wbDat;
    assign wb_ack_o = q.wbAck;
    assign memAddr = q.memAddr;
    assign memWrData = q.memWrData;
    assign memRd = q.memRd;
    assign memWr = q.memWr;
    assign memRfsh = q.memRfsh;
    assign execBusy = q.busy;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Refresh lasts two states per fetch
    AST_RFSH_TWO: assert property ($rose(q.memRfsh) |=> q.memRfsh ##1 !q.memRfsh)
        else $error("refresh not two states");
    AST_COPY_STEP: assert property (endExec && isCopy |=>
        q.src == $past(q.src) - 16'h0001 && q.tgt == $past(q.tgt) - 16'h0001
        && q.cnt == $past(q.cnt) - 16'h0001)
        else $error("copy did not step pointers");
    AST_PC_BACK: assert property (endRep |=> q.pc == $past(q.pc) - 16'h0002)
        else $error("pc not moved back by two");
    AST_ITER_LONG: assert property (endRep |-> q.iterT == 5'd20)
        else $error("repeating iteration not 21 states");
    AST_ITER_SHORT: assert property (endExec && !again |-> q.iterT == 5'd15)
        else $error("final iteration not 16 states");
    AST_COPY_FLAGS: assert property (endExec && isCopy |=>
        q.flags[7:6] == $past(q.flags[7:6]) && !q.flags[`BCSE_FLG_H]
        && !q.flags[`BCSE_FLG_PV] && !q.flags[`BCSE_FLG_N])
        else $error("copy flags wrong");
    AST_CMP_FLAGS: assert property (endExec && !isCopy |=>
        q.flags[`BCSE_FLG_N] && q.flags[`BCSE_FLG_C] == $past(q.flags[`BCSE_FLG_C])
        && q.flags[`BCSE_FLG_Z] == $past(match)
        && q.flags[`BCSE_FLG_PV] == ($past(q.cnt) != 16'h0001))
        else $error("compare flags wrong");
    AST_ACC_HELD: assert property (q.busy ##1 q.busy |-> $stable(q.acc))
        else $error("accumulator changed while busy");
    AST_MATCH_STOPS: assert property (endExec && !isCopy && match |=>
        q.phase == PH_IDLE ##1 !q.busy)
        else $error("match did not end search");
    AST_CMP_UP: assert property (endExec && q.op == OPK_CMP_UP |=>
        q.src == $past(q.src) + 16'h0001)
        else $error("upward compare did not raise source");
    AST_CMP_DOWN: assert property (endExec && q.op == OPK_CMP_DN |=>
        q.src == $past(q.src) - 16'h0001 && q.cnt == $past(q.cnt) - 16'h0001)
        else $error("downward compare did not lower source");
    AST_INT_STOP: assert property (endRep && q.irqS2 |=> !q.busy && q.intTaken)
        else $error("interrupt not accepted between iterations");
endmodule : bcse_exec
`default_nettype wire

/* File: hw/bcse_params.svh */
`ifndef BCSE_PARAMS_SVH
`define BCSE_PARAMS_SVH

// Register byte offsets on the bus
`define BCSE_OFS_CTRL 8'h00
`define BCSE_OFS_PC 8'h04
`define BCSE_OFS_SRC 8'h08
`define BCSE_OFS_TGT 8'h0c
`define BCSE_OFS_CNT 8'h10
`define BCSE_OFS_ACCFLG 8'h14
`define BCSE_OFS_STATUS 8'h18

// Control and status bit positions
`define BCSE_CTRL_START 0
`define BCSE_ST_BUSY 0
`define BCSE_ST_DONE 1
`define BCSE_ST_BADOP 2
`define BCSE_ST_INT 3

// Flag bit positions within the flag byte
`define BCSE_FLG_S 7
`define BCSE_FLG_Z 6
`define BCSE_FLG_H 4
`define BCSE_FLG_PV 2
`define BCSE_FLG_N 1
`define BCSE_FLG_C 0

// Reset values
`define BCSE_RST_WORD 16'h0000
`define BCSE_RST_BYTE 8'h00

// Opcode bytes
`define BCSE_OP_PREFIX 8'hed
`define BCSE_OP_COPY_DN_R 8'hb8
`define BCSE_OP_CMP_UP 8'ha1
`define BCSE_OP_CMP_UP_R 8'hb1
`define BCSE_OP_CMP_DN 8'ha9
`define BCSE_OP_CMP_DN_R 8'hb9

// Machine cycle lengths in clock states, one state per clock
`define BCSE_T_FETCH 4
`define BCSE_T_READ 3
`define BCSE_T_EXEC 5
`define BCSE_T_REPEAT 5
`define BCSE_PC_REWIND 16'h0002

// Data buffer shape
`define BCSE_DATA_W 8
`define BCSE_FIFO_DEPTH 32

`endif

/* File: hw/bcse_pkg.sv */
`default_nettype none
package bcse_pkg;
    typedef logic [15:0] bcse_word_t;
    typedef logic [7:0] bcse_byte_t;

    // Machine cycle currently running
    typedef enum logic [2:0] {
        PH_IDLE, PH_FETCH1, PH_FETCH2, PH_READ, PH_EXEC, PH_REPEAT
    } bcse_phase_t;

    // Decoded block operation
    typedef enum logic [1:0] {OPK_COPY_DN, OPK_CMP_UP, OPK_CMP_DN} bcse_opk_t;

    typedef struct packed {
        bcse_phase_t phase;
        logic [2:0] tCnt;
        bcse_opk_t op;
        logic rep;
        bcse_word_t pc;
        bcse_word_t src;
        bcse_word_t tgt;
        bcse_word_t cnt;
        bcse_byte_t acc;
        bcse_byte_t flags;
        bcse_byte_t data;
        logic busy;
        logic done;
        logic badOp;
        logic intTaken;
        logic [4:0] iterT;
        bcse_word_t memAddr;
        bcse_byte_t memWrData;
        logic memRd;
        logic memWr;
        logic memRfsh;
        logic wbAck;
        logic [31:0] wbDat;
        logic irqS1;
        logic irqS2;
    } bcse_state_t;
endpackage : bcse_pkg
`default_nettype wire

/* File: hw/bcse_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module bcse_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic inValid, // Write side offers a word
    output logic inReady, // Room for a word
    input wire logic [W-1:0] inData, // Word to store
    output logic outValid, // A word waits
    input wire logic outReady, // Read side takes the word
    output logic [W-1:0] outData // Oldest word
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } bcse_fifo_st_t;

    bcse_fifo_st_t q;
    bcse_fifo_st_t n;
    logic push;
    logic pop;

    // Honest full and empty straight from the fill count
    assign inReady = q.cnt != (AW+1)'(D);
    assign outValid = q.cnt != '0;
    assign outData = q.mem[q.rp];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointers wrap by width, so depth must be a power of two
    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wp] = inData;
            n.wp = q.wp + AW'(1);
        end
        if (pop) begin
            n.rp = q.rp + AW'(1);
        end
        n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule : bcse_fifo
`default_nettype wire

/* File: testbench/bcse_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bcse_mem_model (
    input wire logic sys_clk, // Clock
    input wire logic slow, // One wait per access
    input wire bcse_pkg::bcse_word_t memAddr, // Address
    input wire bcse_pkg::bcse_byte_t memWrData, // Write byte
    output bcse_pkg::bcse_byte_t memRdData, // Read byte
    input wire logic memRd, // Read request
    input wire logic memWr, // Write request
    output logic memWait // Wait state
);
    import bcse_pkg::*;
    logic [7:0] mem [0:65535];
    bcse_byte_t lastQ = 8'h00;
    logic [2:0] reqCnt = 3'h0;
    // Idle bus shows the inverse of the last byte, so stale data never matches
    assign memRdData = memRd ? mem[memAddr] : ~lastQ;
    assign memWait = slow && (memRd || memWr) && reqCnt == 3'h1;
    // Wait counting and byte storage
    always @(posedge sys_clk) begin
        reqCnt <= (memRd || memWr) ? reqCnt + 3'h1 : 3'h0;
        if (memRd) lastQ <= mem[memAddr];
        if (memWr && !memWait) mem[memAddr] <= memWrData;
    end
endmodule : bcse_mem_model
`default_nettype wire

/* File: testbench/bcse_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bcse_params.svh"
module bcse_exec_tb;
    import bcse_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h0, wbDatR, q;
    logic wbAck, memRd, memWr, memRfsh, memWait, execBusy, slow = 1'b0, intReq = 1'b0;
    bcse_word_t memAddr, watchPc;
    bcse_byte_t memWrData, memRdData;
    int errors = 0, cmp_count = 0, cyc = 0, tFetch, tEnd, lastDelta, nRf;
    logic pRd, pBusy, pRf;
    logic [7:0] ops [2] = '{8'ha1, 8'ha9};
    always #10 sys_clk = ~sys_clk;
    bcse_exec i_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(4'h3),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .memAddr(memAddr), .memWrData(memWrData),
        .memRdData(memRdData), .memRd(memRd), .memWr(memWr), .memRfsh(memRfsh),
        .memWait(memWait), .intReq(intReq), .execBusy(execBusy));
    bcse_mem_model i_mem (.sys_clk(sys_clk), .slow(slow), .memAddr(memAddr),
        .memWrData(memWrData), .memRdData(memRdData), .memRd(memRd), .memWr(memWr),
        .memWait(memWait));
    // Iteration timing, refresh count and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (memRd && !pRd && memAddr === watchPc) begin
            lastDelta = cyc - tFetch;
            tFetch = cyc;
        end
        if (!execBusy && pBusy) tEnd = cyc;
        if (memRfsh && !pRf) nRf++;
        pRd = memRd;
        pBusy = execBusy;
        pRf = memRfsh;
        if (cyc > 20000) begin
            errors++;
            $display("ERROR %0t timeout", $time);
            final_report();
        end
    end
    task final_report;
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        do @(posedge sys_clk); while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // Start the loaded instruction and wait for it to finish
    task automatic start;
        tFetch = 0;
        nRf = 0;
        wb(1'b1, `BCSE_OFS_CTRL, 32'h1);
        repeat (3) @(posedge sys_clk);
        while (execBusy !== 1'b0) @(posedge sys_clk);
    endtask : start
    task automatic run(input bcse_word_t pc, s, t, n, af, input logic [7:0] op);
        i_mem.mem[pc] = `BCSE_OP_PREFIX;
        i_mem.mem[pc + 16'h1] = op;
        watchPc = pc;
        wb(1'b1, `BCSE_OFS_PC, {16'h0, pc});
        wb(1'b1, `BCSE_OFS_SRC, {16'h0, s});
        wb(1'b1, `BCSE_OFS_TGT, {16'h0, t});
        wb(1'b1, `BCSE_OFS_CNT, {16'h0, n});
        wb(1'b1, `BCSE_OFS_ACCFLG, {16'h0, af});
        start();
    endtask : run
    task automatic flags(input logic [15:0] exp);
        wb(1'b0, `BCSE_OFS_ACCFLG, 32'h0);
        chk(q & 32'h0000d7ff, {16'h0, exp});
    endtask : flags
    task automatic copy_down;
        {i_mem.mem[16'h1112], i_mem.mem[16'h1113], i_mem.mem[16'h1114]} = 24'h8836a5;
        run(16'h0100, 16'h1114, 16'h2225, 16'h0003, 16'hff5a, `BCSE_OP_COPY_DN_R);
        rd(`BCSE_OFS_SRC, 32'h1111);
        rd(`BCSE_OFS_TGT, 32'h2222);
        rd(`BCSE_OFS_CNT, 32'h0000);
        rd(`BCSE_OFS_PC, 32'h0102);
        flags(16'hc15a);
        chk({i_mem.mem[16'h2223], i_mem.mem[16'h2224], i_mem.mem[16'h2225]}, 24'h8836a5);
        chk(lastDelta, 21);
        chk(tEnd - tFetch, 16);
        chk(nRf, 6);
    endtask : copy_down
    task automatic compare_step;
        foreach (ops[i]) begin
            i_mem.mem[16'h3000] = 8'h01;
            run(16'h0200, 16'h3000, 16'h0000, 16'h0001, 16'h0110, ops[i]);
            rd(`BCSE_OFS_SRC, i == 0 ? 32'h3001 : 32'h2fff);
            rd(`BCSE_OFS_CNT, 32'h0000);
            flags(16'h1310);
            chk(i_mem.mem[16'h3000], 8'h01);
            chk(tEnd - tFetch, 16);
        end
    endtask : compare_step
    task automatic search;
        slow <= 1'b1;
        {i_mem.mem[16'h1111], i_mem.mem[16'h1112], i_mem.mem[16'h1113]} = 24'h5200f3;
        run(16'h0300, 16'h1111, 16'h0000, 16'h0007, 16'h00f3, `BCSE_OP_CMP_UP_R);
        rd(`BCSE_OFS_SRC, 32'h1114);
        rd(`BCSE_OFS_CNT, 32'h0004);
        flags(16'h46f3);
        {i_mem.mem[16'h1118], i_mem.mem[16'h1117], i_mem.mem[16'h1116]} = 24'h5200f3;
        run(16'h0300, 16'h1118, 16'h0000, 16'h0007, 16'h00f3, `BCSE_OP_CMP_DN_R);
        rd(`BCSE_OFS_SRC, 32'h1115);
        rd(`BCSE_OFS_CNT, 32'h0004);
        slow <= 1'b0;
        {i_mem.mem[16'hffff], i_mem.mem[16'h0000], i_mem.mem[16'h0001]} = 24'h1122f3;
        run(16'h0400, 16'hffff, 16'h0000, 16'h0000, 16'h00f3, `BCSE_OP_CMP_UP_R);
        rd(`BCSE_OFS_SRC, 32'h0002);
        rd(`BCSE_OFS_CNT, 32'hfffd);
        flags(16'h46f3);
    endtask : search
    task automatic interrupt;
        intReq <= 1'b1;
        run(16'h0500, 16'h1114, 16'h2225, 16'h0000, 16'h005a, `BCSE_OP_COPY_DN_R);
        rd(`BCSE_OFS_CNT, 32'hffff);
        rd(`BCSE_OFS_PC, 32'h0500);
        wb(1'b0, `BCSE_OFS_STATUS, 32'h0);
        chk(q[`BCSE_ST_INT], 1'b1);
        intReq <= 1'b0;
        wb(1'b1, `BCSE_OFS_STATUS, 32'h8);
        // Shorten the wrapped count so the resumed loop ends soon
        wb(1'b1, `BCSE_OFS_CNT, 32'h2);
        start();
        rd(`BCSE_OFS_CNT, 32'h0000);
        rd(`BCSE_OFS_PC, 32'h0502);
        rd(8'h40, 32'h0);
        // Unknown second opcode byte stops after both fetches
        run(16'h0600, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 8'ha0);
        rd(`BCSE_OFS_PC, 32'h0602);
        wb(1'b0, `BCSE_OFS_STATUS, 32'h0);
        chk(q[3:0], 4'h6);
    endtask : interrupt
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        copy_down();
        compare_step();
        search();
        interrupt();
        final_report();
    end
endmodule : bcse_exec_tb
`default_nettype wire
